/* File: rtl/adc_seq_defines.vh */
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_CONTROL_TWO   6'h00
`define ADDR_INPUT_SELECT  6'h04
`define ADDR_SEQ_CONTROL   6'h08
`define ADDR_STATUS        6'h0C
`define ADDR_IRQ_ENABLE    6'h10
`define ADDR_IRQ_CLEAR     6'h14
`define ADDR_STATE         6'h18
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define CTL2_REFERENCE_CONFIG_HI       15
`define CTL2_REFERENCE_CONFIG_LO       13
`define CTL2_OFFSET_CALIBRATION_ENABLE_BIT    12
`define CTL2_SCAN_BIT      10
`define CTL2_SPI_HI        5
`define CTL2_SPI_LO        2
`define CTL2_ALT_BIT       0
`define CTL2_WMASK         16'hF43D
`define CHS_WMASK          16'h8F8F
`define CTL2_RESET         16'h0000
`define CHS_RESET          16'h0000
// ----------------------------------------
// Positive select codes and reference codes
// ----------------------------------------
`define CODE_RESERVED      4'h5
`define REF_SUPPLY         2'h0
`define REF_EXT_POS        2'h1
`define REF_EXT_NEG        2'h1
`define REF_GROUND         2'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ            40
`define SAMPLE_NS          1000
`define CONVERT_NS         3000
`define SAMPLE_CYC         ((`SAMPLE_NS * `CLK_MHZ + 999) / 1000)
`define CONVERT_CYC        ((`CONVERT_NS * `CLK_MHZ + 999) / 1000)
`endif

/* File: rtl/adc_seq_counter.v */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_counter
(
   input  wire       clk,
   input  wire       rst_n,
   input  wire       restart,
   input  wire       seq_done,
   input  wire [3:0] limit,
   output reg        fire
);
   reg [3:0] count;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= 4'h0;
         fire  <= 1'b0;
      end
      else
      begin
         fire <= 1'b0;
         if (restart)
         begin
            count <= 4'h0;
         end
         else if (seq_done)
         begin
            if (count >= limit)
            begin
               count <= 4'h0;
               fire  <= 1'b1;
            end
            else
            begin
               count <= count + 4'h1;
            end
         end
      end
   end
endmodule // adc_seq_counter
`default_nettype wire

/* File: rtl/adc_input_sequence_control.v */
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.vh"
module adc_input_sequence_control
(
   input  wire        SYS_CLK,
   input  wire        RESET_N,
   input  wire [5:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [5:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   output reg  [3:0]  POSITIVE_SELECT,
   output reg         NEGATIVE_INPUT_ONE,
   output reg         SWITCHES_OPEN,
   output reg         INPUTS_GROUNDED,
   output reg         OFFSET_MEASURE,
   output reg  [1:0]  POSITIVE_REFERENCE,
   output reg  [1:0]  NEGATIVE_REFERENCE,
   output reg         SAMPLING,
   output reg         CONVERTING,
   output reg         IRQ
);
   // ----------------------------------------
   // States and timing
   // ----------------------------------------
   localparam [2:0] ST_IDLE    = 3'b001;
   localparam [2:0] ST_SAMPLE  = 3'b010;
   localparam [2:0] ST_CONVERT = 3'b100;
   localparam integer SAMPLE_INT  = `SAMPLE_CYC;
   localparam integer CONVERT_INT = `CONVERT_CYC;
   localparam [7:0]   SAMPLE_LEN  = SAMPLE_INT[7:0];
   localparam [7:0]   CONVERT_LEN = CONVERT_INT[7:0];

   reg [15:0] converter_control_two;
   reg [15:0] converter_input_select;
   reg [15:0] scan_mask;
   reg        run;
   reg [1:0]  status;
   reg [1:0]  irq_enable;
   reg [2:0]  state;
   reg [7:0]  timer;
   reg        use_mux_b;
   reg [3:0]  scan_index;
   reg [3:0]  next_scan;
   reg        aw_hold;
   reg        w_hold;
   reg [5:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   reg        reserved_seen;
   integer    i;

   wire [2:0] reference_config          = converter_control_two[`CTL2_REFERENCE_CONFIG_HI:`CTL2_REFERENCE_CONFIG_LO];
   wire       offset_calibration_enable = converter_control_two[`CTL2_OFFSET_CALIBRATION_ENABLE_BIT];
   wire       scan_mux_a_enable         = converter_control_two[`CTL2_SCAN_BIT];
   wire [3:0] sequences_per_interrupt   = converter_control_two[`CTL2_SPI_HI:`CTL2_SPI_LO];
   wire       alternate_sample_mode     = converter_control_two[`CTL2_ALT_BIT];
   wire       mux_b_negative_select     = converter_input_select[15];
   wire [3:0] mux_b_positive_select     = converter_input_select[11:8];
   wire       mux_a_negative_select     = converter_input_select[7];
   wire [3:0] mux_a_positive_select     = converter_input_select[3:0];

   wire       seq_done;
   wire       sample_end  = (state == ST_SAMPLE) && (timer == 8'h00);
   wire       convert_end = (state == ST_CONVERT) && (timer == 8'h00);
   wire       wr_go = aw_hold && w_hold && !S_AXI_BVALID;
   wire       bad_code;

   // ----------------------------------------
   // Next scan channel
   // ----------------------------------------
   always @*
   begin
      next_scan = scan_index;
      for (i = 15; i >= 1; i = i - 1)
      begin
         if (scan_mask[(scan_index + i[3:0]) & 4'hF])
            next_scan = scan_index + i[3:0];
      end
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   always @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         S_AXI_AWREADY          <= 1'b0;
         S_AXI_WREADY           <= 1'b0;
         S_AXI_BVALID           <= 1'b0;
         S_AXI_BRESP            <= 2'h0;
         aw_hold                <= 1'b0;
         w_hold                 <= 1'b0;
         aw_addr                <= 6'h00;
         w_data                 <= 32'h00000000;
         w_strb                 <= 4'h0;
         converter_control_two  <= `CTL2_RESET;
         converter_input_select <= `CHS_RESET;
         scan_mask              <= 16'h0000;
         run                    <= 1'b0;
         irq_enable             <= 2'h0;
      end
      else
      begin
         S_AXI_AWREADY <= !aw_hold && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY  <= !w_hold && !S_AXI_WREADY && S_AXI_WVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_hold <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_hold <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (S_AXI_BVALID && S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
         if (wr_go)
         begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= 2'h0;
            case (aw_addr)
               `ADDR_CONTROL_TWO:
               begin
                  // Reserved bits 1, 6, 7, 8, 9 and 11 never stored
                  if (w_strb[0])
                     converter_control_two[7:0] <= w_data[7:0] & 8'h3D;
                  if (w_strb[1])
                     converter_control_two[15:8] <= w_data[15:8] & 8'hF4;
               end
               `ADDR_INPUT_SELECT:
               begin
                  if (w_strb[0])
                     converter_input_select[7:0] <= w_data[7:0] & 8'h8F;
                  if (w_strb[1])
                     converter_input_select[15:8] <= w_data[15:8] & 8'h8F;
               end
               `ADDR_SEQ_CONTROL:
               begin
                  if (w_strb[0])
                     run <= w_data[0];
                  if (w_strb[2])
                     scan_mask[7:0] <= w_data[23:16];
                  if (w_strb[3])
                     scan_mask[15:8] <= w_data[31:24];
               end
               `ADDR_IRQ_ENABLE:
                  if (w_strb[0])
                     irq_enable <= w_data[1:0];
               `ADDR_IRQ_CLEAR:
                  S_AXI_BRESP <= 2'h0; // Clear acts in the status block
               default:
                  S_AXI_BRESP <= 2'h2;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Status flags, set wins over clear
   // ----------------------------------------
   wire       seq_irq;
   wire [1:0] clr = (wr_go && aw_addr == `ADDR_IRQ_CLEAR && w_strb[0]) ? w_data[1:0] : 2'h0;
   wire [1:0] set = {sample_end && bad_code, seq_irq};
   assign bad_code = (use_mux_b ? mux_b_positive_select : mux_a_positive_select) == `CODE_RESERVED;

   always @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         status <= 2'h0;
         IRQ    <= 1'b0;
      end
      else
      begin
         status <= (status & ~clr) | set;
         IRQ    <= |(((status & ~clr) | set) & irq_enable);
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   always @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h00000000;
         S_AXI_RRESP   <= 2'h0;
         reserved_seen <= 1'b0;
      end
      else
      begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_RVALID && S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
         if (S_AXI_ARVALID && S_AXI_ARREADY)
         begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= 2'h0;
            reserved_seen <= ~reserved_seen;
            case (S_AXI_ARADDR)
               `ADDR_CONTROL_TWO:
                  S_AXI_RDATA <= {16'h0000, converter_control_two[15:8],
                                  reserved_seen, converter_control_two[6:0]};
               `ADDR_INPUT_SELECT:
                  S_AXI_RDATA <= {16'h0000, converter_input_select};
               `ADDR_SEQ_CONTROL:
                  S_AXI_RDATA <= {scan_mask, 15'h0000, run};
               `ADDR_STATUS:
                  S_AXI_RDATA <= {30'h0, status};
               `ADDR_IRQ_ENABLE:
                  S_AXI_RDATA <= {30'h0, irq_enable};
               `ADDR_STATE:
                  S_AXI_RDATA <= {20'h00000, scan_index, use_mux_b, 4'h0, state};
               default:
               begin
                  S_AXI_RDATA <= 32'h00000000;
                  S_AXI_RRESP <= 2'h2;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Sample and convert sequencer
   // ----------------------------------------
   always @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state      <= ST_IDLE;
         timer      <= 8'h00;
         use_mux_b  <= 1'b0;
         scan_index <= 4'h0;
         SAMPLING   <= 1'b0;
         CONVERTING <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               use_mux_b <= 1'b0;
               if (run)
               begin
                  state    <= ST_SAMPLE;
                  timer    <= SAMPLE_LEN - 8'h01;
                  SAMPLING <= 1'b1;
                  // A scan never starts on a channel outside a non-empty mask
                  if (scan_mux_a_enable && !scan_mask[scan_index])
                     scan_index <= next_scan;
               end
            end
            ST_SAMPLE:
            begin
               if (timer == 8'h00)
               begin
                  state      <= ST_CONVERT;
                  timer      <= CONVERT_LEN - 8'h01;
                  SAMPLING   <= 1'b0;
                  CONVERTING <= 1'b1;
               end
               else
                  timer <= timer - 8'h01;
            end
            ST_CONVERT:
            begin
               if (timer != 8'h00)
                  timer <= timer - 8'h01;
               else
               begin
                  CONVERTING <= 1'b0;
                  use_mux_b  <= alternate_sample_mode && !use_mux_b;
                  if (scan_mux_a_enable && !use_mux_b)
                     scan_index <= next_scan;
                  if (run)
                  begin
                     state    <= ST_SAMPLE;
                     timer    <= SAMPLE_LEN - 8'h01;
                     SAMPLING <= 1'b1;
                  end
                  else
                     state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // A sequence ends after mux B when alternating, else after each conversion
   assign seq_done = convert_end && (!alternate_sample_mode || use_mux_b);

   adc_seq_counter u_counter
   (
      .clk      (SYS_CLK),
      .rst_n    (RESET_N),
      .restart  (!run),
      .seq_done (seq_done),
      .limit    (sequences_per_interrupt),
      .fire     (seq_irq)
   );

   // Mux choice and scan channel for the sample about to start
   wire       next_mux_b = (state == ST_IDLE) ? 1'b0 : (alternate_sample_mode && !use_mux_b);
   wire [3:0] next_a     = (state == ST_IDLE) ?
                           (scan_mask[scan_index] ? scan_index : next_scan) :
                           (use_mux_b ? scan_index : next_scan);

   // ----------------------------------------
   // Analog switch drive, latched per sample
   // ----------------------------------------
   always @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         POSITIVE_SELECT    <= 4'h0;
         NEGATIVE_INPUT_ONE <= 1'b0;
         SWITCHES_OPEN      <= 1'b1;
         INPUTS_GROUNDED    <= 1'b0;
         OFFSET_MEASURE     <= 1'b0;
         POSITIVE_REFERENCE <= `REF_SUPPLY;
         NEGATIVE_REFERENCE <= `REF_GROUND;
      end
      else if ((state == ST_IDLE && run) || (convert_end && run))
      begin
         // Codes pass straight through; the mux decodes them
         OFFSET_MEASURE  <= offset_calibration_enable;
         INPUTS_GROUNDED <= offset_calibration_enable;
         SWITCHES_OPEN   <= offset_calibration_enable;
         if (offset_calibration_enable)
         begin
            POSITIVE_SELECT    <= 4'h0;
            NEGATIVE_INPUT_ONE <= 1'b0;
         end
         else if (next_mux_b)
         begin
            POSITIVE_SELECT    <= mux_b_positive_select;
            NEGATIVE_INPUT_ONE <= mux_b_negative_select;
         end
         else
         begin
            POSITIVE_SELECT    <= scan_mux_a_enable ? next_a : mux_a_positive_select;
            NEGATIVE_INPUT_ONE <= mux_a_negative_select;
         end
         case (reference_config)
            3'h1:
            begin
               POSITIVE_REFERENCE <= `REF_EXT_POS;
               NEGATIVE_REFERENCE <= `REF_GROUND;
            end
            3'h2:
            begin
               POSITIVE_REFERENCE <= `REF_SUPPLY;
               NEGATIVE_REFERENCE <= `REF_EXT_NEG;
            end
            3'h3:
            begin
               POSITIVE_REFERENCE <= `REF_EXT_POS;
               NEGATIVE_REFERENCE <= `REF_EXT_NEG;
            end
            default:
            begin
               POSITIVE_REFERENCE <= `REF_SUPPLY;
               NEGATIVE_REFERENCE <= `REF_GROUND;
            end
         endcase
      end
   end

endmodule // adc_input_sequence_control
`default_nettype wire

/* File: test/adc_seq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor
(
   input wire logic       SYS_CLK,
   input wire logic       RESET_N,
   input wire logic       S_AXI_AWREADY,
   input wire logic       S_AXI_BVALID,
   input wire logic       S_AXI_BREADY,
   input wire logic [3:0] POSITIVE_SELECT,
   input wire logic       NEGATIVE_INPUT_ONE,
   input wire logic       SWITCHES_OPEN,
   input wire logic       INPUTS_GROUNDED,
   input wire logic       OFFSET_MEASURE,
   input wire logic [1:0] POSITIVE_REFERENCE,
   input wire logic [1:0] NEGATIVE_REFERENCE,
   input wire logic       SAMPLING,
   input wire logic       CONVERTING
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   // --------
   // Sequencer timing
   // --------
   chk_sample_window: assert property
      ($rose(SAMPLING) |-> SAMPLING ##39 SAMPLING ##1 (!SAMPLING && CONVERTING))
      else $error("sample period length wrong");
   chk_convert_window: assert property
      ($rose(CONVERTING) |-> ##119 CONVERTING ##1 !CONVERTING)
      else $error("conversion length wrong");
   chk_phase_exclusive: assert property (!(SAMPLING && CONVERTING))
      else $error("sample and conversion overlap");
   // Switches may only move on the first sample cycle
   chk_switch_hold: assert property
      ((CONVERTING || (SAMPLING && $past(SAMPLING))) |->
       $stable(POSITIVE_SELECT) && $stable(NEGATIVE_INPUT_ONE))
      else $error("switch codes moved mid sequence");
   // --------
   // Calibration and references
   // --------
   chk_calib_ground: assert property
      (OFFSET_MEASURE |-> SWITCHES_OPEN && INPUTS_GROUNDED)
      else $error("offset mode without grounded inputs");
   chk_calib_pair: assert property (INPUTS_GROUNDED == OFFSET_MEASURE)
      else $error("ground and offset flags disagree");
   chk_ref_range: assert property
      (POSITIVE_REFERENCE <= 2'h1 && NEGATIVE_REFERENCE <= 2'h1)
      else $error("reference code out of range");
   // --------
   // Register bus
   // --------
   chk_awready_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
      else $error("address ready held");
   chk_bvalid_single: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response repeated");
endmodule // adc_seq_monitor
bind adc_input_sequence_control adc_seq_monitor i_mon (.SYS_CLK, .RESET_N, .S_AXI_AWREADY,
   .S_AXI_BVALID, .S_AXI_BREADY, .POSITIVE_SELECT, .NEGATIVE_INPUT_ONE, .SWITCHES_OPEN,
   .INPUTS_GROUNDED, .OFFSET_MEASURE, .POSITIVE_REFERENCE, .NEGATIVE_REFERENCE,
   .SAMPLING, .CONVERTING);
`default_nettype wire

/* File: test/analog_mux_model.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_mux_model
(
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic [3:0] pos_select,
   input wire logic       neg_input_one,
   input wire logic       sampling,
   input wire logic       converting
);
   logic [4:0] sample_code;
   int         sample_count;
   int         conv_count;
   logic       was_sampling;
   logic       was_converting;
   // Switches are taken as they stand at sample start
   always @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         sample_code <= 5'h00;
         sample_count <= 0;
         conv_count <= 0;
         was_sampling <= 1'b0;
         was_converting <= 1'b0;
      end
      else
      begin
         was_sampling <= sampling;
         was_converting <= converting;
         if (sampling && !was_sampling)
         begin
            sample_code <= {neg_input_one, pos_select};
            sample_count <= sample_count + 1;
         end
         if (was_converting && !converting)
            conv_count <= conv_count + 1;
      end
endmodule // analog_mux_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   wire         awready, wready, bvalid, arready, rvalid, neg_one, sw_open;
   wire         grounded, offset, sampling, converting, irq;
   wire  [1:0]  bresp, rresp, pos_ref, neg_ref;
   wire  [31:0] rdata;
   wire  [3:0]  pos_sel;
   int          errors, total_checks;
   adc_input_sequence_control i_adc_input_sequence_control (.SYS_CLK(sys_clk),
      .RESET_N(reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .POSITIVE_SELECT(pos_sel), .NEGATIVE_INPUT_ONE(neg_one), .SWITCHES_OPEN(sw_open),
      .INPUTS_GROUNDED(grounded), .OFFSET_MEASURE(offset), .POSITIVE_REFERENCE(pos_ref),
      .NEGATIVE_REFERENCE(neg_ref), .SAMPLING(sampling), .CONVERTING(converting), .IRQ(irq));
   analog_mux_model mux (.sys_clk(sys_clk), .reset_n(reset_n), .pos_select(pos_sel),
      .neg_input_one(neg_one), .sampling(sampling), .converting(converting));
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // --------
   // Shared tasks
   // --------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task timeout_hit;
      errors++;
      tally_and_finish();
   endtask
   task wr(input logic [5:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 50) timeout_hit();
      chk(bresp, 32'h0);
      bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 50) timeout_hit();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Stop, load, clear flags, run: each test starts from sequence one
   task start(input logic [15:0] ctl, input logic [15:0] sel, input logic [31:0] seq);
      int n;
      wr(6'h08, 32'h0);
      // A stopped run still finishes its current conversion; load only once idle
      for (n = 0; n < 200 && (sampling || converting); n++) @(posedge sys_clk);
      if (n == 200) timeout_hit();
      wr(6'h00, {16'h0, ctl});
      wr(6'h04, {16'h0, sel});
      wr(6'h14, 32'h3);
      wr(6'h08, seq);
   endtask
   task wait_sample;
      int n, c0;
      c0 = mux.sample_count;
      for (n = 0; n < 400 && mux.sample_count == c0; n++) @(posedge sys_clk);
      if (n == 400) timeout_hit();
   endtask
   // --------
   // Scenarios
   // --------
   task t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      chk({sw_open, grounded, offset, sampling, irq}, 32'h10);
      rd(6'h00, d, r);
      chk(d & 32'hFFFF_FF7F, 32'h0);
      rd(6'h04, d, r);
      chk(d, 32'h0);
      wr(6'h00, 32'hFFFF_FFFD);
      rd(6'h00, d, r);
      chk(d & 32'hFFFF_FF7F, 32'hF43D);
      wr(6'h04, 32'hFFFF_FFFF);
      rd(6'h04, d, r);
      chk(d, 32'h8F8F);
      rd(6'h3C, d, r);
      chk(r, 32'h2);
   endtask
   task t_refs;
      for (int v = 0; v < 8; v++)
      begin
         start(16'(v) << 13, 16'h0009, 32'h1);
         wait_sample();
         chk(pos_ref, (v == 1 || v == 3));
         chk(neg_ref, (v == 2 || v == 3));
      end
   endtask
   task t_calib;
      start(16'h1000, 16'h8C89, 32'h1);
      wait_sample();
      chk({sw_open, grounded, offset}, 32'h7);
      start(16'h0000, 16'h8C89, 32'h1);
      wait_sample();
      chk({sw_open, grounded, offset}, 32'h0);
   endtask
   task t_codes;
      // Inputs three, four, ten and eleven left out for the small package; code five is reserved
      logic [3:0] codes [11] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'h9, 4'h8, 4'h7, 4'h6, 4'h2, 4'h1,
                                 4'h0};
      foreach (codes[i])
      begin
         start(16'h0000, {8'h8D, codes[i][0], 3'h0, codes[i]}, 32'h1);
         wait_sample();
         wait_sample();
         chk({neg_one, pos_sel}, {codes[i][0], codes[i]});
      end
   endtask
   task t_alt;
      start(16'h0001, 16'h8C09, 32'h1);
      for (int k = 0; k < 4; k++)
      begin
         wait_sample();
         chk(mux.sample_code, (k % 2) ? 32'h1C : 32'h09);
      end
   endtask
   task t_scan;
      logic [3:0] s;
      start(16'h0400, 16'h0009, 32'h0024_0001);
      wait_sample();
      s = mux.sample_code[3:0];
      chk(s == 4'h2 || s == 4'h5, 32'h1);
      wait_sample();
      chk(mux.sample_code[3:0], 4'h7 - s);
      wait_sample();
      chk(mux.sample_code[3:0], s);
   endtask
   task t_irq;
      logic [31:0] d;
      logic [1:0]  r;
      int          m, n, c0;
      for (int i = 0; i < 3; i++)
      begin
         m = (i == 2) ? 3 : i;
         wr(6'h10, 32'h1);
         start(16'(m) << 2, 16'h0009, 32'h1);
         c0 = mux.conv_count;
         for (n = 0; n < 1200 && irq !== 1'b1; n++) @(posedge sys_clk);
         if (n == 1200) timeout_hit();
         chk(mux.conv_count - c0, m + 1);
         wr(6'h10, 32'h0);
         repeat (2) @(posedge sys_clk);
         chk(irq, 32'h0);
         rd(6'h0C, d, r);
         chk(d[0], 32'h1);
         wr(6'h10, 32'h1);
         repeat (2) @(posedge sys_clk);
         chk(irq, 32'h1);
         // Stop first so no new sequence sets the flag again
         wr(6'h08, 32'h0);
         wr(6'h14, 32'h1);
         rd(6'h0C, d, r);
         chk(d[0], 32'h0);
      end
      wr(6'h08, 32'h0);
   endtask
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 44'h0;
      wstrb = 4'hF;
      reset_n = 1'b0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_refs();
      t_calib();
      t_codes();
      t_alt();
      t_scan();
      t_irq();
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
